// file: chu_top.sv
// Purpose: Colour history table, its per-group update and previous-line references.
// Assumes: Group and line strobes come from logic on REF_CLK_IN.
// Notes: The table output is registered and lags a change by one cycle.
//
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "chu_cfg.svh"
module chu_top
   import chu_pkg::*;
#(
   parameter int MAX_W = 64
)
(
   input  wire logic                  REF_CLK_IN,
   input  wire logic                  RST_N_IN,
   input  wire logic                  HSEL_IN,
   input  wire logic [31:0]           HADDR_IN,
   input  wire logic [1:0]            HTRANS_IN,
   input  wire logic                  HWRITE_IN,
   input  wire logic [2:0]            HSIZE_IN,
   input  wire logic [31:0]           HWDATA_IN,
   input  wire logic                  HREADY_IN,
   output logic [31:0]                HRDATA_OUT,
   output logic                       HREADYOUT_OUT,
   output logic                       HRESP_OUT,
   input  wire logic                  SLICE_START_IN,
   input  wire logic                  LINE_START_IN,
   input  wire logic                  GRP_VALID_IN,
   input  wire chu_grp_t              GRP_IN,
   output logic                       GRP_READY_OUT,
   output chu_tab_t                   ENTRY_OUT,
   output logic [`CHU_NPOS-1:0]       ENTRY_VALID_OUT,
   output logic                       FIRST_LINE_OUT
);
   localparam int AW = (MAX_W > 1) ? $clog2(MAX_W) : 1;

   if (MAX_W < `CHU_NREF || MAX_W > 65535) begin : g_bad_width
      $error("MAX_W must lie between 7 and 65535");
   end

   typedef chu_ent_t [2:0][MAX_W-1:0] mem_t;

   typedef struct packed {
      mem_t                  mem;
      chu_tab_t              hist;
      logic [`CHU_NPOS-1:0]  hval;
      chu_tab_t              view;
      logic [`CHU_NPOS-1:0]  vval;
      logic [1:0]            bank;
      logic [15:0]           line;
      logic [15:0]           hpos;
      logic                  stale;
   } st_t;

   st_t                  s;
   st_t                  n;
   chu_cfg_t             cfg;
   chu_stat_t            stat;
   chu_tab_t             vw;
   logic [`CHU_NPOS-1:0] vv;
   chu_tab_t             ich_tab;
   logic [`CHU_NPOS-1:0] ich_val;
   chu_ent_t [`CHU_NREF-1:0] refs;
   logic                 first;
   logic                 take;
   logic                 last;
   logic [16:0]          wid;
   logic [1:0]           pbank;
   logic [1:0]           cbank;

   function automatic logic [1:0] bank_add(input logic [1:0] b, input logic [1:0] d);
      logic [2:0] t;
      t = {1'b0, b} + {1'b0, d};
      bank_add = (t >= 3'd3) ? 2'(t - 3'd3) : t[1:0];
   endfunction

   function automatic logic [AW-1:0] clamp_addr(input logic [16:0] a);
      clamp_addr = (a >= 17'(MAX_W)) ? AW'(MAX_W - 1) : a[AW-1:0];
   endfunction

   function automatic chu_samp_t luma(input mem_t m, input logic [1:0] b,
                                      input logic [16:0] j);
      chu_ent_t e;
      e = m[b][clamp_addr({1'b0, j[16:1]})];
      luma = j[0] ? e.y2 : e.y;
   endfunction

   function automatic logic [5:0] popcnt(input logic [`CHU_NPOS-1:0] v);
      logic [5:0] c;
      c = 6'h00;
      for (int i = 0; i < `CHU_NPOS; i++) begin
         c = c + {5'h00, v[i]};
      end
      popcnt = c;
   endfunction

   chu_ahb_regs u_regs (
      .clk_in     (REF_CLK_IN),
      .rst_n_in   (RST_N_IN),
      .hsel_in    (HSEL_IN),
      .haddr_in   (HADDR_IN),
      .htrans_in  (HTRANS_IN),
      .hwrite_in  (HWRITE_IN),
      .hwdata_in  (HWDATA_IN),
      .hready_in  (HREADY_IN),
      .stat_in    (stat),
      .hrdata_out (HRDATA_OUT),
      .cfg_out    (cfg)
   );

   chu_upd_order u_order (
      .tab_in   (vw),
      .val_in   (vv),
      .idx_in   (GRP_IN.idx),
      .first_in (first),
      .tab_out  (ich_tab),
      .val_out  (ich_val)
   );

   assign first = (s.line == 16'h0000);
   assign wid   = {1'b0, cfg.slice_w};
   assign pbank = bank_add(s.bank, 2'h2);
   // Two lines back carries the chroma type of this line.
   assign cbank = (cfg.n420 && s.line >= 16'h0002) ? bank_add(s.bank, 2'h1) : pbank;

   // Previous-line reference window for the group at hpos.
   always_comb begin
      logic [16:0] rs;
      logic [16:0] lw;
      chu_ent_t    ce;
      rs = 17'h0_0000;
      lw = 17'h0_0000;
      ce = '0;
      refs = '0;
      if (cfg.n422 || cfg.n420) begin
         lw = {wid[15:0], 1'b0};
         if (s.hpos != 16'h0000) begin
            rs = {s.hpos, 1'b0} - 17'h0_0001;
         end
         if (rs + 17'h0_0008 > lw) begin
            rs = (lw >= 17'h0_0008) ? lw - 17'h0_0008 : 17'h0_0000;
         end
         for (int k = 0; k < `CHU_NREF; k++) begin
            refs[k].y  = luma(s.mem, pbank, rs + 17'(k));
            refs[k].y2 = luma(s.mem, pbank, rs + 17'(k + 1));
            ce = s.mem[cbank][clamp_addr((rs + 17'(k)) >> 1)];
            refs[k].c0 = ce.c0;
            refs[k].c1 = cfg.n420 ? '0 : ce.c1;
         end
      end else begin
         if (s.hpos != 16'h0000) begin
            rs = {1'b0, s.hpos} - 17'h0_0002;
         end
         if (rs + 17'h0_0007 > wid) begin
            rs = (wid >= 17'h0_0007) ? wid - 17'h0_0007 : 17'h0_0000;
         end
         for (int k = 0; k < `CHU_NREF; k++) begin
            refs[k] = s.mem[pbank][clamp_addr(rs + 17'(k))];
         end
      end
   end

   // The table as the encoder sees it.
   always_comb begin
      vw = s.hist;
      vv = s.hval;
      if (!first) begin
         for (int p = `CHU_NHIST; p < `CHU_NPOS; p++) begin
            vw[p] = refs[p - `CHU_NHIST];
            vv[p] = 1'b1;
         end
      end
   end

   // A strobe or a fresh update holds groups off, so each sees settled state.
   assign take = GRP_VALID_IN & GRP_READY_OUT;
   assign last = ({1'b0, s.hpos} + 17'h0_0003) >= wid;

   always_comb begin
      logic [16:0] a;
      n = s;
      n.stale = 1'b0;
      a = 17'h0_0000;
      if (SLICE_START_IN) begin
         n.line  = 16'h0000;
         n.hpos  = 16'h0000;
         n.hval  = '0;
         n.bank  = bank_add(s.bank, 2'h1);
         n.stale = 1'b1;
      end else if (LINE_START_IN) begin
         n.line  = s.line + 16'h0001;
         n.hpos  = 16'h0000;
         n.bank  = bank_add(s.bank, 2'h1);
         n.stale = 1'b1;
         if (cfg.pic_w != cfg.slice_w) begin
            n.hval = '0;
         end
      end else if (take) begin
         n.stale = 1'b1;
         n.hpos  = s.hpos + 16'h0003;
         for (int i = 0; i < 3; i++) begin
            a = {1'b0, s.hpos} + 17'(i);
            if (a < wid) begin
               n.mem[s.bank][clamp_addr(a)] = GRP_IN.recon[i];
            end
         end
         if (!last) begin
            if (GRP_IN.ich) begin
               n.hist = ich_tab;
               n.hval = ich_val;
            end else begin
               // No duplicate check: equal colours may occupy several slots.
               for (int p = `CHU_NPOS - 1; p >= 3; p--) begin
                  n.hist[p] = s.hist[p - 3];
                  n.hval[p] = s.hval[p - 3];
               end
               for (int p = 0; p < 3; p++) begin
                  n.hist[p] = GRP_IN.recon[2 - p];
                  n.hval[p] = 1'b1;
               end
            end
         end
      end
      n.view = vw;
      n.vval = vv;
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (!RST_N_IN) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   always_comb begin
      stat.line  = s.line;
      stat.first = first;
      stat.nval  = popcnt(s.vval);
   end

   assign GRP_READY_OUT   = cfg.en & ~s.stale & ~SLICE_START_IN & ~LINE_START_IN;
   assign ENTRY_OUT       = s.view;
   assign ENTRY_VALID_OUT = s.vval;
   assign FIRST_LINE_OUT  = first;
   assign HREADYOUT_OUT   = 1'b1;
   assign HRESP_OUT       = 1'b0;

   logic unused_ok;
   assign unused_ok = ^HSIZE_IN;
endmodule // chu_top
`default_nettype wire

// file: chu_cfg.svh
// Purpose: Offsets, field positions, reset values and sizes of the colour history block.
// Assumes: Included by every design file; the guard keeps it single.
// Notes: Offsets are AHB-Lite byte addresses, one 32-bit word each.
// Operation
// - The table offers exactly 32 selectable index positions.
// - Later slice lines: 0..24 are history, 25..31 point at previous-line pixels.
// - On the first slice line all 32 positions are history.
// - An entry holds one colour of the active colour space, two lumas when native.
// - History is a shift register with the most recent entry at position 0.
// - Each slice start empties the history of valid entries.
// - Predictive groups push three reconstructed pixels, dropping the three oldest.
// - On later lines position 24 is the oldest history entry.
// - A line's first group references the first seven previous-line pixels.
// - Later groups reference two left, three above and two right on the previous line.
// - A window leaving the slice uses the last seven previous-line pixels.
// - Native 4:2:0 chroma is untagged and references take it from two lines back, but from the previous line on the second slice line.
// - Native luma pairs start at any sample, covering six above plus one each side.
// - Native reference windows shift at slice edges to stay in the raster.
// - Insertion never checks for duplicate colours.
// - History changes once per group; all three indices see the old state.
// - Repeated indices drop all but their last occurrence; rightmost unique ones update.
// - Third pixel's entry becomes newest, then second's, then first's.
// - Other entries move down by the count of used indices above them.
// - The same update serves history and previous-line positions.
// - The last or partial group of a line leaves the history unchanged.
// - Picture width unlike slice width invalidates history at every line start.
`ifndef CHU_CFG_SVH
`define CHU_CFG_SVH
`define CHU_NPOS 32
`define CHU_NHIST 25
`define CHU_NREF 7
`define CHU_SAMP_W 10
`define CHU_IDX_W 5
`define CHU_OFS_CTRL 8'h00
`define CHU_OFS_SWID 8'h04
`define CHU_OFS_PWID 8'h08
`define CHU_OFS_STAT 8'h0C
`define CHU_CTRL_EN 0
`define CHU_CTRL_N422 1
`define CHU_CTRL_N420 2
`define CHU_STAT_NVAL 0
`define CHU_STAT_FIRST 8
`define CHU_STAT_LINE 16
`define CHU_WID_RST 16'h0000
`endif

// file: chu_pkg.sv
// Purpose: Types shared by the colour history block.
// Assumes: chu_cfg.svh supplies the sizes.
// Notes: The 4:2:0 chroma sample always sits in the c0 field.
`include "chu_cfg.svh"
package chu_pkg;
   typedef logic [`CHU_SAMP_W-1:0] chu_samp_t;
   typedef logic [`CHU_IDX_W-1:0] chu_idx_t;
   typedef struct packed {
      chu_samp_t y2;
      chu_samp_t c1;
      chu_samp_t c0;
      chu_samp_t y;
   } chu_ent_t;
   typedef chu_ent_t [`CHU_NPOS-1:0] chu_tab_t;
   typedef struct packed {
      logic                   ich;
      chu_idx_t [2:0]         idx;
      chu_ent_t [2:0]         recon;
   } chu_grp_t;
   typedef struct packed {
      logic                   en;
      logic                   n422;
      logic                   n420;
      logic [15:0]            slice_w;
      logic [15:0]            pic_w;
   } chu_cfg_t;
   typedef struct packed {
      logic [15:0]            line;
      logic                   first;
      logic [5:0]             nval;
   } chu_stat_t;
endpackage

// file: chu_ahb_regs.sv
// Purpose: AHB-Lite slave holding the control, width and status words.
// Assumes: Single word transfers; zero wait states.
// Notes: Read data is captured at the address phase, with a pending write bypassed.
`timescale 1ns/10ps
`default_nettype none
`include "chu_cfg.svh"
module chu_ahb_regs
   import chu_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   input  wire chu_stat_t   stat_in,
   output logic [31:0]      hrdata_out,
   output chu_cfg_t         cfg_out
);
   typedef struct packed {
      chu_cfg_t    cfg;
      logic        wpend;
      logic [7:0]  wofs;
      logic [31:0] rdata;
   } st_t;
   st_t s;
   st_t n;
   logic take;

   function automatic logic [31:0] rd(input logic [7:0] a, input chu_cfg_t c,
                                      input chu_stat_t t);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         `CHU_OFS_CTRL: r = {29'h0000_0000, c.n420, c.n422, c.en};
         `CHU_OFS_SWID: r = {16'h0000, c.slice_w};
         `CHU_OFS_PWID: r = {16'h0000, c.pic_w};
         `CHU_OFS_STAT: r = {t.line, 7'h00, t.first, 2'h0, t.nval};
         default:       r = 32'h0000_0000;
      endcase
      rd = r;
   endfunction

   assign take = hsel_in & htrans_in[1] & hready_in;

   always_comb begin
      n = s;
      n.wpend = 1'b0;
      if (s.wpend) begin
         unique case (s.wofs)
            `CHU_OFS_CTRL: begin
               n.cfg.en   = hwdata_in[`CHU_CTRL_EN];
               n.cfg.n422 = hwdata_in[`CHU_CTRL_N422];
               n.cfg.n420 = hwdata_in[`CHU_CTRL_N420];
            end
            `CHU_OFS_SWID: n.cfg.slice_w = hwdata_in[15:0];
            `CHU_OFS_PWID: n.cfg.pic_w = hwdata_in[15:0];
            default: n.cfg = s.cfg;
         endcase
      end
      if (take) begin
         n.wpend = hwrite_in;
         n.wofs  = {haddr_in[7:2], 2'b00};
         n.rdata = rd({haddr_in[7:2], 2'b00}, n.cfg, stat_in);
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign hrdata_out = s.rdata;
   assign cfg_out    = s.cfg;
endmodule // chu_ahb_regs
`default_nettype wire

// file: chu_upd_order.sv
// Purpose: Reorders the table after a history-coded group.
// Assumes: The table given is the state seen by all three indices.
// Notes: Positions past the history length come out invalid.
`timescale 1ns/10ps
`default_nettype none
`include "chu_cfg.svh"
module chu_upd_order
   import chu_pkg::*;
(
   input  wire chu_tab_t              tab_in,
   input  wire logic [`CHU_NPOS-1:0]  val_in,
   input  wire chu_idx_t [2:0]        idx_in,
   input  wire logic                  first_in,
   output chu_tab_t                   tab_out,
   output logic [`CHU_NPOS-1:0]       val_out
);
   always_comb begin
      logic u1;
      logic u0;
      int   cnt;
      int   lim;
      u1  = idx_in[1] != idx_in[2];
      u0  = (idx_in[0] != idx_in[1]) && (idx_in[0] != idx_in[2]);
      lim = first_in ? `CHU_NPOS : `CHU_NHIST;
      tab_out = '0;
      val_out = '0;
      tab_out[0] = tab_in[idx_in[2]];
      val_out[0] = val_in[idx_in[2]];
      cnt = 1;
      if (u1) begin
         tab_out[cnt] = tab_in[idx_in[1]];
         val_out[cnt] = val_in[idx_in[1]];
         cnt = cnt + 1;
      end
      if (u0) begin
         tab_out[cnt] = tab_in[idx_in[0]];
         val_out[cnt] = val_in[idx_in[0]];
         cnt = cnt + 1;
      end
      // Unused entries keep their order, so each moves by the used indices above it.
      for (int j = 0; j < `CHU_NPOS; j++) begin
         if (j < lim && cnt < lim && j != int'(idx_in[2])
             && !(u1 && j == int'(idx_in[1])) && !(u0 && j == int'(idx_in[0]))) begin
            tab_out[cnt] = tab_in[j];
            val_out[cnt] = val_in[j];
            cnt = cnt + 1;
         end
      end
   end
endmodule // chu_upd_order
`default_nettype wire

// file: chu_checker.sv
// Purpose: Port-level assertions for the colour history table.
// Assumes: Bound to chu_top; one clock with a synchronous active-low reset.
// Notes: The table view lags a take by two edges, so checks look two cycles on.
`timescale 1ns/10ps
`default_nettype none
`include "chu_cfg.svh"
module chu_checker
   import chu_pkg::*;
#(
   parameter int MAX_W = 64
)
(
   input  wire logic                 REF_CLK_IN,
   input  wire logic                 RST_N_IN,
   input  wire logic                 SLICE_START_IN,
   input  wire logic                 LINE_START_IN,
   input  wire logic                 GRP_VALID_IN,
   input  wire chu_grp_t             GRP_IN,
   input  wire logic                 GRP_READY_OUT,
   input  wire chu_tab_t             ENTRY_OUT,
   input  wire logic [`CHU_NPOS-1:0] ENTRY_VALID_OUT,
   input  wire logic                 FIRST_LINE_OUT
);
   logic                 take;
   logic                 strobe;
   chu_tab_t             h_old;
   logic [`CHU_NPOS-1:0] h_val;
   chu_grp_t             h_grp;
   assign take   = GRP_VALID_IN && GRP_READY_OUT;
   assign strobe = SLICE_START_IN || LINE_START_IN;
   // A snapshot of the view at the take lets the update be judged two edges later.
   always_ff @(posedge REF_CLK_IN) begin
      if (take) begin
         h_old <= ENTRY_OUT;
         h_val <= ENTRY_VALID_OUT;
         h_grp <= GRP_IN;
      end
   end
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   a_ready_gate: assert property (GRP_READY_OUT |-> !strobe)
      else $error("group ready during a line strobe");
   a_one_per_group: assert property (take |=> !GRP_READY_OUT)
      else $error("second group accepted in the cycle after a take");
   a_ready_return: assert property (take ##2 !strobe |-> GRP_READY_OUT)
      else $error("group ready did not return two cycles after a take");
   a_slice_clear: assert property (SLICE_START_IN |-> ##2 (ENTRY_VALID_OUT == '0))
      else $error("entries still valid after a slice start");
   a_first_flag: assert property (SLICE_START_IN |-> ##2 FIRST_LINE_OUT)
      else $error("first line flag missing after a slice start");
   a_later_refs: assert property (LINE_START_IN && !SLICE_START_IN |-> ##2
      (!FIRST_LINE_OUT && (&ENTRY_VALID_OUT[31:25])))
      else $error("previous line positions not offered on a later line");
   a_pred_push: assert property (take && !GRP_IN.ich |-> ##2
      ((ENTRY_OUT[0] == h_grp.recon[2] && ENTRY_OUT[1] == h_grp.recon[1]
      && ENTRY_OUT[2] == h_grp.recon[0] && ENTRY_VALID_OUT[2:0] == 3'h7)
      || (ENTRY_OUT == h_old && ENTRY_VALID_OUT == h_val)))
      else $error("predictive group not pushed as most recent");
   a_ich_mru: assert property (take && GRP_IN.ich |-> ##2
      ((ENTRY_OUT[0] == h_old[h_grp.idx[2]] && ENTRY_VALID_OUT[0])
      || (ENTRY_OUT == h_old && ENTRY_VALID_OUT == h_val)))
      else $error("third pixel entry did not become most recent");
   a_quiet_between: assert property
      ($changed(ENTRY_OUT) || $changed(ENTRY_VALID_OUT) |-> $past(take || strobe, 2))
      else $error("table changed without a group or strobe");
   c_pred: cover property (take && !GRP_IN.ich);
   c_ich: cover property (take && GRP_IN.ich);
   c_line: cover property (LINE_START_IN && !SLICE_START_IN);
endmodule // chu_checker
bind chu_top chu_checker #(.MAX_W(MAX_W)) chu_checker_i (
   .REF_CLK_IN      (REF_CLK_IN),
   .RST_N_IN        (RST_N_IN),
   .SLICE_START_IN  (SLICE_START_IN),
   .LINE_START_IN   (LINE_START_IN),
   .GRP_VALID_IN    (GRP_VALID_IN),
   .GRP_IN          (GRP_IN),
   .GRP_READY_OUT   (GRP_READY_OUT),
   .ENTRY_OUT       (ENTRY_OUT),
   .ENTRY_VALID_OUT (ENTRY_VALID_OUT),
   .FIRST_LINE_OUT  (FIRST_LINE_OUT)
);
`default_nettype wire

// file: chu_partner.sv
// Purpose: Stand-in for the encoder mode decision that offers groups to the table.
// Assumes: Requests change just after a rising edge and hold until taken.
// Notes: Released group data is inverted so a stale value never passes for a live one.
`timescale 1ns/10ps
`default_nettype none
module chu_partner
   import chu_pkg::*;
(
   input  wire logic    clk_in,
   input  wire logic    grp_ready_in,
   output var logic     grp_valid_out,
   output var chu_grp_t grp_out
);
   initial begin
      grp_valid_out = 1'b0;
      grp_out       = '0;
   end
   task automatic send(input logic ich, input chu_idx_t [2:0] idx,
                       input chu_ent_t [2:0] recon, input int nreal,
                       input bit slice_first, output bit ok);
      chu_grp_t g;
      int       n;
      g.ich   = ich && !slice_first;
      g.idx   = idx;
      g.recon = recon;
      for (int k = nreal; k < 3; k++) begin
         g.idx[k] = idx[nreal-1];
      end
      @(posedge clk_in);
      grp_valid_out <= 1'b1;
      grp_out       <= g;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (grp_ready_in !== 1'b1 && n < 64);
      ok = (grp_ready_in === 1'b1);
      grp_valid_out <= 1'b0;
      grp_out       <= ~g;
   endtask
endmodule // chu_partner
`default_nettype wire

// file: chu_top_tb.sv
// Purpose: Self-checking bench for the colour history table.
// Assumes: 4:4:4 coding with a 35-container slice, so each line ends in a partial group.
// Notes: A queue model, most recent first, predicts every view; the last slice is native 4:2:2.
`timescale 1ns/10ps
`default_nettype none
`include "chu_cfg.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin fails++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module chu_top_tb
   import chu_pkg::*;
;
   localparam int W = 35;
   logic        ref_clk;
   logic        rst_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic        slice_start;
   logic        line_start;
   logic        grp_valid;
   chu_grp_t    grp;
   logic        grp_ready;
   chu_tab_t    entry;
   logic [31:0] entry_val;
   logic        first_line;
   int          fails;
   int          cmp_count;
   int          seed;
   int          hpos;
   int          line_no;
   int          pic_w;
   bit          first;
   bit          nat;
   chu_ent_t    hq[$];
   chu_ent_t    prev[64];
   chu_ent_t    cur[64];
   always #4 ref_clk = ~ref_clk;
   chu_top #(.MAX_W(64)) chu_top_i (
      .REF_CLK_IN(ref_clk), .RST_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
      .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
      .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
      .SLICE_START_IN(slice_start), .LINE_START_IN(line_start), .GRP_VALID_IN(grp_valid),
      .GRP_IN(grp), .GRP_READY_OUT(grp_ready), .ENTRY_OUT(entry),
      .ENTRY_VALID_OUT(entry_val), .FIRST_LINE_OUT(first_line));
   chu_partner chu_partner_i (.clk_in(ref_clk), .grp_ready_in(grp_ready),
      .grp_valid_out(grp_valid), .grp_out(grp));
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   function automatic chu_ent_t ent(int p);
      int       rs;
      chu_ent_t e;
      if (first || p < 25) return hq[p];
      if (nat) begin
         rs = (hpos == 0) ? 0 : ((2 * hpos + 7 > 2 * W) ? 2 * W - 8 : 2 * hpos - 1);
         rs += p - 25;
         // Luma pairs may start on an odd sample, so the pair straddles two containers.
         e = prev[rs / 2];
         e.y  = rs[0] ? prev[rs / 2].y2 : e.y;
         e.y2 = rs[0] ? prev[rs / 2 + 1].y : e.y2;
         return e;
      end
      rs = (hpos == 0) ? 0 : ((hpos - 2 > W - 7) ? W - 7 : hpos - 2);
      return prev[rs + p - 25];
   endfunction
   task automatic check_view();
      logic [31:0] ev;
      for (int p = 0; p < 32; p++) begin
         ev[p] = (p < hq.size()) || (!first && p > 24);
         if (ev[p]) `CHK("entry", ent(p), entry[p])
      end
      `CHK("valid", ev, entry_val)
      `CHK("first line", first, first_line)
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      if (hready !== 1'b1) begin
         fails++;
         conclude();
      end
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge ref_clk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask
   task automatic strobe(input bit slice);
      @(posedge ref_clk);
      slice_start <= slice;
      line_start  <= !slice;
      @(posedge ref_clk);
      slice_start <= 1'b0;
      line_start  <= 1'b0;
      if (slice) begin
         hq.delete();
         line_no = 0;
      end else begin
         prev = cur;
         line_no++;
         if (pic_w != W) hq.delete();
         while (hq.size() > 25) hq.pop_back();
      end
      first = slice;
      hpos = 0;
      repeat (2) @(posedge ref_clk);
      #1;
      check_view();
   endtask
   task automatic group(input bit ich, input chu_idx_t [2:0] idx);
      chu_ent_t [2:0] rc;
      chu_ent_t       nq[$];
      bit             used[32];
      bit             ok;
      int             nreal;
      logic [63:0]    r;
      for (int k = 0; k < 3; k++) begin
         r = {$random(seed), $random(seed)};
         // A history-coded pixel is reconstructed as the entry that it selects.
         rc[k] = ich ? ent(idx[k]) : r[39:0];
      end
      nreal = (W - hpos < 3) ? W - hpos : 3;
      chu_partner_i.send(ich, idx, rc, nreal, first && hpos == 0, ok);
      if (!ok) begin
         fails++;
         conclude();
      end
      for (int k = 0; k < nreal; k++) begin
         cur[hpos + k] = ich ? ent(idx[k]) : rc[k];
      end
      // The last group of a line only feeds the line store.
      if (hpos + 3 < W) begin
         used = '{default: 1'b0};
         for (int k = 2; k >= 0; k--) begin
            if (!ich) begin
               hq.push_front(rc[2-k]);
            end else if (!used[idx[k]]) begin
               used[idx[k]] = 1'b1;
               nq.push_back(ent(idx[k]));
            end
         end
         for (int p = 0; ich && p < hq.size(); p++) begin
            if (!used[p]) nq.push_back(hq[p]);
         end
         if (ich) hq = nq;
         while (hq.size() > (first ? 32 : 25)) hq.pop_back();
         hpos += 3;
      end
      repeat (2) @(posedge ref_clk);
      #1;
      check_view();
   endtask
   // Bit 15 marks a history-coded group; the rest is {third, second, first} index.
   function automatic logic [15:0] pick(int n);
      case (n)
         2:       return {1'b1, 5'h01, 5'h04, 5'h01};
         4:       return {1'b1, 5'h08, 5'h07, 5'h00};
         11:      return {1'b1, 5'h03, 5'h03, 5'h02};
         12:      return {1'b1, 5'h19, 5'h1E, 5'h03};
         17:      return {1'b1, 5'h18, 5'h1A, 5'h18};
         default: return 16'h0000;
      endcase
   endfunction
   initial begin
      logic [31:0] rd;
      logic [15:0] pk;
      ref_clk = 1'b0;
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      slice_start = 1'b0;
      line_start = 1'b0;
      fails = 0;
      cmp_count = 0;
      seed = 957;
      hpos = 0;
      line_no = 0;
      first = 1'b1;
      nat = 1'b0;
      pic_w = W;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      `CHK("reset valid", 32'h0, entry_val)
      `CHK("reset ready", 1'b0, grp_ready)
      ahb(1'b1, `CHU_OFS_CTRL, 32'h1, rd);
      ahb(1'b1, `CHU_OFS_SWID, 32'(W), rd);
      ahb(1'b1, `CHU_OFS_PWID, 32'(W), rd);
      ahb(1'b1, `CHU_OFS_STAT, 32'hFFFF_FFFF, rd);
      ahb(1'b0, `CHU_OFS_SWID, 32'h0, rd);
      `CHK("slice width", 32'(W), rd)
      ahb(1'b0, 32'h10, 32'h0, rd);
      `CHK("unmapped", 32'h0, rd)
      strobe(1'b1);
      for (int n = 0; n < 24; n++) begin
         pk = pick(n);
         group(pk[15], pk[14:0]);
         if (n == 11) strobe(1'b0);
      end
      pic_w = W + 1;
      ahb(1'b1, `CHU_OFS_PWID, 32'(pic_w), rd);
      strobe(1'b0);
      ahb(1'b0, `CHU_OFS_STAT, 32'h0, rd);
      `CHK("status", (32'(line_no) << 16) | 32'(hq.size() + 7), rd)
      `CHK("response", 1'b0, hresp)
      strobe(1'b1);
      // The mode changes on a first line, where the previous-line positions are hidden.
      ahb(1'b1, `CHU_OFS_CTRL, 32'h3, rd);
      nat = 1'b1;
      for (int n = 0; n < 24; n++) begin
         group(1'b0, 15'h0000);
         if (n == 11) strobe(1'b0);
      end
      conclude();
   end
endmodule // chu_top_tb
`default_nettype wire
